// *** spdp_port.sv ***
// Purpose: Serial download port: shifts four-byte instructions in on the
//          programmer clock and runs erase, write and read of the arrays.
// Assumes: Programmer honours clock phase minimums and the wait delays.
// Notes:   Arrays change only when a self-timed write ends; the link side
//          reads them directly as quasi-static values.
`timescale 1ns/1ps
`include "spdp_defs.svh"

module spdp_port #(
  parameter int          FLASH_AW  = 14,  // Flash word address width
  parameter int          EE_AW     = 10,  // EEPROM byte address width
  parameter int          PAGE_AW   = 6,   // Word offset bits in a page
  parameter int          FLASH_CYC = `SPDP_T_FLASH_US * `SPDP_CLK_MHZ,
  parameter int          EE_CYC    = `SPDP_T_EEPROM_US * `SPDP_CLK_MHZ,
  parameter int          ERASE_CYC = `SPDP_T_ERASE_US * `SPDP_CLK_MHZ,
  parameter int          FUSE_CYC  = `SPDP_T_FUSE_US * `SPDP_CLK_MHZ,
  parameter logic [31:0] SIGNATURE = 32'h00_5a_3c_1e, // Arbitrary value
  parameter logic [31:0] CALIB     = 32'h80_80_80_80  // Calibration bytes
) (
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic               sck,
  input  wire logic               mosi,
  input  wire logic               reset_pin_n,
  output logic                    miso,
  output logic                    prog_mode,
  output logic                    busy,
  output spdp_pkg::spdp_state_t   seq_state
);
  import spdp_pkg::*;

  localparam int PGN = FLASH_AW - PAGE_AW;  // Page number width

  // ----------------------------------------------------------------
  // Storage shared by both domains, except the system-side page buffer
  // ----------------------------------------------------------------
  logic [15:0] flash   [2**FLASH_AW];   // Program flash words
  logic [7:0]  eeprom  [2**EE_AW];      // Data EEPROM bytes
  logic [7:0]  pbuf_lo [2**PAGE_AW];    // Page buffer low bytes
  logic [7:0]  pbuf_hi [2**PAGE_AW];    // Page buffer high bytes
  logic [5:0]  lock;                    // Lock bits, zero = programmed
  logic [7:0]  fuse_lo;                 // Fuse low byte
  logic [7:0]  fuse_hi;                 // Fuse high byte
  logic [31:0] pend;                    // Instruction of the running write
  logic [PGN-1:0]   pend_page;          // Page number of the running write
  logic [EE_AW-1:0] pend_ee;            // EEPROM address of the running write
  logic        fl_busy;                 // Flash write running, plain flop
  logic        ee_busy;                 // EEPROM write running, plain flop

  // ----------------------------------------------------------------
  // Link domain (programmer clock, cleared while reset pin high)
  // ----------------------------------------------------------------
  logic [4:0]  bit_cnt;                 // Bits taken in this instruction
  logic [31:0] rx_sh;                   // Input shift register
  logic [31:0] cmd_word;                // Last complete forwarded word
  logic        cmd_tgl;                 // Flips once per forwarded word
  logic        prog_en;                 // Programming mode entered
  logic [7:0]  tx_sh;                   // Output shift register
  logic [1:0]  fl_busy_s;               // Flash busy synchroniser
  logic [1:0]  ee_busy_s;               // EEPROM busy synchroniser
  logic [7:0]  rd_byte;                 // Answer for byte four
  logic [31:0] rx_next;                 // Shift register after this edge

  assign rx_next = {rx_sh[30:0], mosi};

  // Bit framing and input shift on the rising edge
  always_ff @(posedge sck or posedge reset_pin_n) begin
    if (reset_pin_n) begin           // Port idle while reset pin high
      bit_cnt <= 5'h00;              // RULE1
      rx_sh   <= 32'h0000_0000;
    end else begin
      bit_cnt <= bit_cnt + 5'h01;    // RULE24
      rx_sh   <= rx_next;            // RULE5
    end
  end

  // Mode entry and hand-off of whole instructions
  // The word is held until the next 32nd edge, which leaves the system side
  // many cycles to take it after the toggle arrives.
  always_ff @(posedge sck or posedge reset_pin_n) begin
    if (reset_pin_n) begin
      prog_en  <= 1'b0;
      cmd_word <= 32'h0000_0000;
      cmd_tgl  <= 1'b0;
    end else if (bit_cnt == 5'h1f) begin
      // Enable instruction, last two bytes ignored
      if (rx_next[31:16] == {`SPDP_OP_ENABLE, `SPDP_B2_ENABLE}) begin
        prog_en <= 1'b1;             // RULE10
      end else if (prog_en) begin    // Nothing runs before enable
        cmd_word <= rx_next;         // RULE2
        cmd_tgl  <= ~cmd_tgl;
      end
    end
  end

  // Busy levels brought onto the programmer clock
  always_ff @(posedge sck or posedge reset_pin_n) begin
    if (reset_pin_n) begin
      fl_busy_s <= 2'h0;
      ee_busy_s <= 2'h0;
    end else begin
      fl_busy_s <= {fl_busy_s[0], fl_busy};
      ee_busy_s <= {ee_busy_s[0], ee_busy};
    end
  end

  // Read answer from bytes one to three
  // Arrays are read straight across the domain boundary; they only change
  // at the end of a timed write, while busy hides the page or byte under a flash or EEPROM write.
  always_comb begin
    rd_byte = 8'h00;
    if (prog_en) begin
      casez (rx_sh[23:16])
        `SPDP_OP_RD_FLASH: begin
          // Polling a page under write sees all ones
          if (fl_busy_s[1] && rx_sh[FLASH_AW-1:PAGE_AW] == pend_page) begin
            rd_byte = `SPDP_ERASED;  // RULE15
          end else if (rx_sh[`SPDP_H_BIT]) begin
            rd_byte = flash[rx_sh[FLASH_AW-1:0]][15:8];  // RULE18
          end else begin
            rd_byte = flash[rx_sh[FLASH_AW-1:0]][7:0];
          end
        end
        `SPDP_OP_RD_EE: begin
          // Polling the byte under write sees all ones
          if (ee_busy_s[1] && rx_sh[EE_AW-1:0] == pend_ee) begin
            rd_byte = `SPDP_ERASED;  // RULE17
          end else begin
            rd_byte = eeprom[rx_sh[EE_AW-1:0]];  // RULE19
          end
        end
        `SPDP_OP_RD_LOCK: begin
          // Same first byte for lock and fuse high
          if (rx_sh[15:8] == `SPDP_B2_RD_FUSEHI) begin
            rd_byte = fuse_hi;       // RULE21
          end else begin
            rd_byte = {2'b11, lock}; // RULE20
          end
        end
        `SPDP_OP_RD_FUSE: begin
          rd_byte = fuse_lo;         // RULE21
        end
        `SPDP_OP_RD_SIG: begin
          rd_byte = SIGNATURE[{rx_sh[1:0], 3'b000} +: 8];  // RULE22
        end
        `SPDP_OP_RD_CAL: begin
          rd_byte = CALIB[{rx_sh[1:0], 3'b000} +: 8];      // RULE22
        end
        default: begin
          rd_byte = 8'h00;           // No data for other instructions
        end
      endcase
    end
  end

  // Output shift on the falling edge
  always_ff @(negedge sck or posedge reset_pin_n) begin
    if (reset_pin_n) begin
      tx_sh <= 8'h00;
    end else if (bit_cnt == 5'h10) begin
      tx_sh <= rx_sh[7:0];           // RULE8
    end else if (bit_cnt == 5'h18) begin
      tx_sh <= rd_byte;              // RULE5
    end else begin
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  assign miso = tx_sh[7];

  // ----------------------------------------------------------------
  // System domain
  // ----------------------------------------------------------------
  logic [2:0]  tgl_s;                   // Toggle synchroniser and history
  logic [1:0]  pm_s;                    // Mode synchroniser
  logic        cmd_stb;                 // One pulse per new instruction
  logic [19:0] wait_cnt;                // Self-timed delay counter
  logic        done;                    // Last cycle of a timed write
  spdp_state_t next_busy;               // Write started by this word

  // Which timed write an instruction starts
  function automatic spdp_state_t write_kind(input logic [15:0] b12);
    casez (b12)
      {`SPDP_OP_ENABLE, `SPDP_B2_ERASE}:     write_kind = SPDP_ERASE;
      {`SPDP_OP_ENABLE, `SPDP_B2_WR_LOCK}:   write_kind = SPDP_FUSE;
      {`SPDP_OP_ENABLE, `SPDP_B2_WR_FUSE}:   write_kind = SPDP_FUSE;
      {`SPDP_OP_ENABLE, `SPDP_B2_WR_FUSEHI}: write_kind = SPDP_FUSE;
      {`SPDP_OP_WR_PAGE, 8'b????_????}:      write_kind = SPDP_FLASH;
      {`SPDP_OP_WR_EE, 8'b????_????}:        write_kind = SPDP_EE;
      default:                               write_kind = SPDP_IDLE;
    endcase
  endfunction

  // Delay of each timed write in cycles
  function automatic logic [19:0] wait_len(input spdp_state_t k);
    unique case (k)
      SPDP_FLASH: wait_len = 20'(FLASH_CYC - 1);
      SPDP_EE:    wait_len = 20'(EE_CYC - 1);
      SPDP_ERASE: wait_len = 20'(ERASE_CYC - 1);
      SPDP_FUSE:  wait_len = 20'(FUSE_CYC - 1);
      SPDP_IDLE:  wait_len = 20'h0_0000;
    endcase
  endfunction

  // Crossing of the instruction toggle and the mode level
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tgl_s <= 3'h0;
      pm_s  <= 2'h0;
    end else begin
      tgl_s <= {tgl_s[1:0], cmd_tgl};
      pm_s  <= {pm_s[0], prog_en};
    end
  end

  assign cmd_stb   = tgl_s[2] ^ tgl_s[1];
  assign prog_mode = pm_s[1];
  assign next_busy = write_kind(cmd_word[31:16]);
  assign done      = (seq_state != SPDP_IDLE) && (wait_cnt == 20'h0_0000);

  // Write sequencer and busy flag
  // A new write is taken only from idle, so a write sent while busy is
  // dropped rather than queued; the programmer polls or waits instead.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      seq_state <= SPDP_IDLE;
      wait_cnt  <= 20'h0_0000;
      busy      <= 1'b0;
    end else begin
      unique case (seq_state)
        SPDP_IDLE: begin
          // New writes only while idle
          if (cmd_stb && next_busy != SPDP_IDLE) begin
            seq_state <= next_busy;
            wait_cnt  <= wait_len(next_busy);
            busy      <= 1'b1;
          end
        end
        SPDP_FLASH, SPDP_EE, SPDP_ERASE, SPDP_FUSE: begin
          if (done) begin
            seq_state <= SPDP_IDLE;
            busy      <= 1'b0;
          end else begin
            wait_cnt <= wait_cnt - 20'h0_0001;
          end
        end
      endcase
    end
  end

  // Capture of the instruction that starts a write
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pend <= 32'h0000_0000;
    end else if (seq_state == SPDP_IDLE && cmd_stb && next_busy != SPDP_IDLE) begin
      pend <= cmd_word;
    end
  end

  // Address fields of the latched write: byte two at [23:16], three at [15:8]
  assign pend_page = pend[FLASH_AW+7:PAGE_AW+8];
  assign pend_ee   = pend[EE_AW+7:8];

  // Busy kinds held in flops so the link side samples no decode glitch
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fl_busy <= 1'b0;
      ee_busy <= 1'b0;
    end else begin
      fl_busy <= (seq_state == SPDP_FLASH);
      ee_busy <= (seq_state == SPDP_EE);
    end
  end

  // Page buffer: bytewise loads, cleared after commit
  always_ff @(posedge clk_sys) begin
    if (reset || (done && seq_state == SPDP_FLASH)) begin
      for (int i = 0; i < 2**PAGE_AW; i++) begin
        pbuf_lo[i] <= `SPDP_ERASED;
        pbuf_hi[i] <= `SPDP_ERASED;
      end
    end else if (cmd_stb && seq_state == SPDP_IDLE) begin
      casez (cmd_word[31:24])
        `SPDP_OP_LD_PAGE: begin
          // Offset from byte three, data from byte four
          if (cmd_word[`SPDP_H_BIT_WORD]) begin
            pbuf_hi[cmd_word[PAGE_AW+7:8]] <= cmd_word[7:0];  // RULE11
          end else begin
            pbuf_lo[cmd_word[PAGE_AW+7:8]] <= cmd_word[7:0];  // RULE11
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Flash array: page commit or erase at end of delay
  always_ff @(posedge clk_sys) begin
    if (done && seq_state == SPDP_FLASH) begin
      for (int i = 0; i < 2**PAGE_AW; i++) begin
        flash[{pend_page, PAGE_AW'(i)}] <= {pbuf_hi[i], pbuf_lo[i]};  // RULE12
      end
    end else if (done && seq_state == SPDP_ERASE) begin
      for (int i = 0; i < 2**FLASH_AW; i++) begin
        flash[i] <= {`SPDP_ERASED, `SPDP_ERASED};  // RULE3
      end
    end
  end

  // EEPROM array: erase-then-write lands as one update
  always_ff @(posedge clk_sys) begin
    if (done && seq_state == SPDP_EE) begin
      eeprom[pend_ee] <= pend[7:0];  // RULE14
    end else if (done && seq_state == SPDP_ERASE) begin
      for (int i = 0; i < 2**EE_AW; i++) begin
        eeprom[i] <= `SPDP_ERASED;           // RULE3
      end
    end
  end

  // Lock and fuse bytes; lock bits only clear by erase or reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lock    <= `SPDP_LOCK_RST;
      fuse_lo <= `SPDP_FUSE_LO_RST;
      fuse_hi <= `SPDP_FUSE_HI_RST;
    end else if (done && seq_state == SPDP_ERASE) begin
      lock <= `SPDP_LOCK_RST;
    end else if (done && seq_state == SPDP_FUSE) begin
      casez (pend[23:16])
        `SPDP_B2_WR_LOCK: begin
          lock <= lock & pend[5:0];    // RULE20
        end
        `SPDP_B2_WR_FUSE: begin
          fuse_lo <= pend[7:0];        // RULE21
        end
        `SPDP_B2_WR_FUSEHI: begin
          fuse_hi <= pend[7:0];        // RULE21
        end
        default: begin
        end
      endcase
    end
  end

endmodule

// *** spdp_defs.svh ***
// Purpose: Constants for the serial program download port.
// Assumes: 100 MHz system clock; all byte codes are the instruction bytes.
// Notes:   Times are kept in microseconds and turned into cycles in the port.
// How it works
// RULE1 - Three wires, live only while reset low
// RULE2 - Programming enable must precede program or erase
// RULE3 - Chip erase sets flash and EEPROM all ones
// RULE4 - Programmer keeps clock phases above 2-3 cycles
// RULE5 - Sample input on rise, launch output on fall
// RULE6 - Programmer powers up with reset, clock low
// RULE7 - Programmer waits 20 ms before enable
// RULE8 - Echo second enable byte during third byte
// RULE9 - Programmer sends four bytes, resyncs via reset
// RULE10 - Bytes ac 53 enter programming mode
// RULE11 - Page buffer loaded bytewise, low before high
// RULE12 - Write page commits buffer to addressed page
// RULE13 - Programmer waits 4.5 ms after page write
// RULE14 - EEPROM write erases then writes the byte
// RULE15 - Reads inside busy page return all ones
// RULE16 - Programmer waits full delay for all-ones data
// RULE17 - Read of busy EEPROM byte returns ones
// RULE18 - Flash read returns selected word byte
// RULE19 - EEPROM read returns addressed byte
// RULE20 - Lock bits written and read back
// RULE21 - Fuse low and high written and read
// RULE22 - Signature and calibration bytes read back
// RULE23 - Programmer releases reset to end session
// RULE24 - Frame eight edges per byte, four bytes
`ifndef SPDP_DEFS_SVH
`define SPDP_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SPDP_CLK_MHZ       100
`define SPDP_T_FLASH_US    4500
`define SPDP_T_EEPROM_US   9000
`define SPDP_T_ERASE_US    9000
`define SPDP_T_FUSE_US     4500

// ----------------------------------------------------------------
// Instruction byte codes
// ----------------------------------------------------------------
`define SPDP_OP_ENABLE     8'hac
`define SPDP_B2_ENABLE     8'h53
`define SPDP_OP_RD_FLASH   8'b0010_?000
`define SPDP_OP_LD_PAGE    8'b0100_?000
`define SPDP_OP_WR_PAGE    8'h4c
`define SPDP_OP_RD_EE      8'ha0
`define SPDP_OP_WR_EE      8'hc0
`define SPDP_OP_RD_LOCK    8'h58
`define SPDP_OP_RD_FUSE    8'h50
`define SPDP_OP_RD_SIG     8'h30
`define SPDP_OP_RD_CAL     8'h38
`define SPDP_B2_ERASE      8'b100?_????
`define SPDP_B2_WR_LOCK    8'b111?_????
`define SPDP_B2_WR_FUSE    8'ha0
`define SPDP_B2_WR_FUSEHI  8'ha8
`define SPDP_B2_RD_FUSEHI  8'h08
// H bit: 19 in the three bytes shifted so far, 27 in a whole word
`define SPDP_H_BIT         19
`define SPDP_H_BIT_WORD    27

// ----------------------------------------------------------------
// Reset and erased values
// ----------------------------------------------------------------
`define SPDP_LOCK_RST      6'h3f
`define SPDP_FUSE_LO_RST   8'hff
`define SPDP_FUSE_HI_RST   8'hff
`define SPDP_ERASED        8'hff

`endif

// *** spdp_pkg.sv ***
// Purpose: Types for the serial program download port.
// Assumes: Nothing beyond the constants header.
// Notes:   One-hot codes for the self-timed write sequencer.
package spdp_pkg;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    SPDP_IDLE  = 5'b00001,
    SPDP_FLASH = 5'b00010,
    SPDP_EE    = 5'b00100,
    SPDP_ERASE = 5'b01000,
    SPDP_FUSE  = 5'b10000
  } spdp_state_t;

endpackage

// *** spdp_port_assertions.sv ***
// Purpose: Pin-level checks on the serial download port.
// Assumes: Erase time of the instance is passed in as MAXC.
// Notes:   Bound into every spdp_port.
`timescale 1ns/1ps
module spdp_port_assertions #(
  parameter int MAXC = 900000  // Longest write time
) (
  input wire logic             clk_sys,
  input wire logic             reset,
  input wire logic             sck,
  input wire logic             mosi,
  input wire logic             reset_pin_n,
  input wire logic             miso,
  input wire logic             prog_mode,
  input wire logic             busy,
  input spdp_pkg::spdp_state_t seq_state
);
  import spdp_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  int unsigned busy_cnt;  // Cycles of the running write
  // Count the length of each write
  always_ff @(posedge clk_sys) begin
    if (reset || !busy) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  sequence s_pin_high;
    reset_pin_n [*4];
  endsequence
  sequence s_write_start;
    $rose(busy);
  endsequence
  a_write_needs_mode: assert property (s_write_start |-> prog_mode)
    else $error("write began outside programming mode");
  a_busy_state: assert property (busy |-> seq_state != SPDP_IDLE)
    else $error("busy with idle sequencer");
  a_busy_bounded: assert property (busy |-> busy_cnt <= MAXC + 8)
    else $error("write ran too long");
  a_pin_exit_mode: assert property (s_pin_high |-> ##1 !prog_mode)
    else $error("mode kept with reset pin high");
  a_pin_idle_miso: assert property (s_pin_high |-> !miso)
    else $error("miso driven with reset pin high");
  a_miso_on_fall: assert property ($changed(miso) && !reset_pin_n |-> !sck)
    else $error("miso changed while sck high");
  a_mode_in_pin: assert property ($rose(prog_mode) |-> !reset_pin_n)
    else $error("mode entered with reset pin high");
  a_mode_stays: assert property (prog_mode && !reset_pin_n |=> prog_mode)
    else $error("mode lost with reset pin low");
endmodule
bind spdp_port spdp_port_assertions #(.MAXC(ERASE_CYC)) i_chk (
  .clk_sys(clk_sys), .reset(reset), .sck(sck), .mosi(mosi), .reset_pin_n(reset_pin_n),
  .miso(miso), .prog_mode(prog_mode), .busy(busy), .seq_state(seq_state));

// *** spdp_prog_model.sv ***
// Purpose: Programmer model: serial master of the download port.
// Assumes: Link clock period 30 ns, low between frames.
// Notes:   Gap after each frame covers the hand-off to clk_sys.
`timescale 1ns/1ps
module spdp_prog_model #(
  // Half link clock period; link logic runs on sck itself
  parameter realtime HALF = 15.0
) (
  output logic      sck,
  output logic      mosi,
  output logic      reset_pin_n,
  input  wire logic miso
);
  // Power up with reset pin and clock low
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    reset_pin_n = 1'b0;
  end
  // High pulse on the reset pin, clock held low
  task automatic pin_pulse(input realtime hi);
    reset_pin_n = 1'b1;
    #(hi);
    reset_pin_n = 1'b0;
    #(100);
  endtask
  // All four bytes msb first, reply gathered on rising edges
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
    #2.3;
    for (int i = 31; i >= 0; i--) begin
      mosi = cmd[i];
      #(HALF);
      sck = 1'b1;
      rsp[i] = miso;
      #(HALF);
      sck = 1'b0;
    end
    mosi = ~mosi;     // Line driven to the inverse of the last bit sent
    #(100);
  endtask
endmodule

// *** spdp_port_tb_top.sv ***
// Purpose: Self-checking bench for the serial download port.
// Assumes: Write times cut to 300 cycles, 256 flash words.
// Notes:   Model drives the link; bench waits on busy, bounded.
`timescale 1ns/1ps
module spdp_port_tb_top;
  import spdp_pkg::*;
  localparam int          WCYC = 300;              // Short write time
  localparam logic [31:0] SIG  = 32'h00_c3_b2_a1;  // Arbitrary value
  localparam logic [31:0] CAL  = 32'h9e_8d_7c_6b;  // Arbitrary value
  logic        clk_sys;
  logic        reset;
  wire logic   sck;
  wire logic   mosi;
  wire logic   reset_pin_n;
  logic        miso;
  logic        prog_mode;
  logic        busy;
  spdp_state_t seq_state;
  int          errors;
  int          cmp_count;
  logic [31:0] rsp;
  spdp_port #(.FLASH_AW(8), .FLASH_CYC(WCYC), .EE_CYC(WCYC), .ERASE_CYC(WCYC),
    .FUSE_CYC(WCYC), .SIGNATURE(SIG), .CALIB(CAL)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .sck(sck), .mosi(mosi), .reset_pin_n(reset_pin_n),
    .miso(miso), .prog_mode(prog_mode), .busy(busy), .seq_state(seq_state));
  spdp_prog_model i_prog (.sck(sck), .mosi(mosi), .reset_pin_n(reset_pin_n), .miso(miso));
  // Counts, verdict, end of run
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One instruction; byte 3 must echo byte 2
  task automatic send(input logic [31:0] cmd);
    i_prog.xfer(cmd, rsp);
    chk("echo", cmd[23:16], rsp[15:8]);
  endtask
  task automatic run(input logic [31:0] cmd, input logic [7:0] exp);
    send(cmd);
    chk("read", exp, rsp[7:0]);
  endtask
  // Start a write and confirm the sequencer state
  task automatic start(input logic [31:0] cmd, input spdp_state_t st);
    send(cmd);
    repeat (4) @(posedge clk_sys);
    #1;
    chk("state", {3'h0, st}, {3'h0, seq_state});
    chk("busy", 8'h01, {7'h0, busy});
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 2000) begin
      errors++;
      $display("[FAIL] busy expected 0 seen %b", busy);
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [31:0] cmd, input spdp_state_t st);
    start(cmd, st);
    wait_idle();
  endtask
  // Only the enable is taken before mode entry
  task automatic t_refuse();
    i_prog.pin_pulse(30.0);
    run(32'h30_00_01_00, 8'h00);
    send(32'hc0_00_05_5a);
    repeat (8) @(posedge clk_sys);
    chk("busy", 8'h00, {7'h0, busy});
    chk("mode", 8'h00, {7'h0, prog_mode});
    repeat (20) @(posedge clk_sys);
    send(32'hac_53_00_00);
    repeat (6) @(posedge clk_sys);
    chk("mode", 8'h01, {7'h0, prog_mode});
  endtask
  // Erase, then byte writes with auto-erase and busy reads
  task automatic t_arrays();
    wr(32'hac_80_00_00, SPDP_ERASE);
    run(32'ha0_03_ff_00, 8'hff);
    run(32'h28_00_ff_00, 8'hff);
    start(32'hc0_02_05_5a, SPDP_EE);
    run(32'ha0_02_05_00, 8'hff);
    send(32'hc0_02_06_11);
    wait_idle();
    run(32'ha0_02_05_00, 8'h5a);
    run(32'ha0_02_06_00, 8'hff);
    start(32'hc0_02_05_a5, SPDP_EE);
    run(32'ha0_02_05_00, 8'hff);
    wait_idle();
    run(32'ha0_02_05_00, 8'ha5);
    run(32'ha0_00_05_00, 8'hff);
  endtask
  // Page load, commit to page 1, poll inside the page
  task automatic t_flash();
    send(32'h40_00_03_34);
    send(32'h48_00_03_12);
    start(32'h4c_00_40_00, SPDP_FLASH);
    run(32'h20_00_7f_00, 8'hff);
    wait_idle();
    run(32'h20_00_43_00, 8'h34);
    run(32'h28_00_43_00, 8'h12);
    run(32'h20_00_03_00, 8'hff);
    send(32'h40_00_03_56);
    start(32'h4c_00_40_00, SPDP_FLASH);
    run(32'h20_00_43_00, 8'hff);
    wait_idle();
    run(32'h20_00_43_00, 8'h56);
    run(32'h28_00_43_00, 8'hff);
  endtask
  // Lock and fuse bytes, then identity bytes
  task automatic t_fuse_ids();
    wr(32'hac_e0_00_f0, SPDP_FUSE);
    run(32'h58_00_00_00, 8'hf0);
    wr(32'hac_a0_00_e1, SPDP_FUSE);
    wr(32'hac_a8_00_d9, SPDP_FUSE);
    run(32'h50_00_00_00, 8'he1);
    run(32'h58_08_00_00, 8'hd9);
    for (int i = 0; i < 4; i++) begin
      run({16'h30_00, 6'h00, i[1:0], 8'h00}, SIG[8*i+:8]);
      run({16'h38_00, 6'h00, i[1:0], 8'h00}, CAL[8*i+:8]);
    end
  endtask
  // Releasing the reset pin ends the session
  task automatic t_exit();
    i_prog.pin_pulse(200.0);
    chk("mode", 8'h00, {7'h0, prog_mode});
    run(32'h20_00_43_00, 8'h00);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    errors = 0;
    cmp_count = 0;
    reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 reset = 1'b0;
    t_refuse();
    t_arrays();
    t_flash();
    t_fuse_ids();
    t_exit();
    tally_and_finish();
  end
endmodule
